//--- hw/prot_host_regs.sv
// Purpose: Host register bank of the battery protector front end
// Assumes: Serial slave decodes frames into one-cycle reg_wr/reg_rd strobes
// Notes: Read data appears one cycle after reg_rd; analog inputs are synced
// How it works
// RULE1 - Host writes control registers only in host mode
// RULE2 - Status bit0 flags short circuit, resets zero
// RULE3 - Status bit1 flags overload above threshold
// RULE4 - Status bit2 flags cell overvoltage
// RULE5 - Status bit3 flags cell undervoltage
// RULE6 - Status bit4 flags overtemperature
// RULE7 - Status bit5 shows programming supply good
// RULE8 - Status bits 6,7 show switch states
// RULE9 - Toggling release bit clears latches on read
// RULE10 - Host mode: control bits drive switches
// RULE11 - Control bit3 pulls open-drain output low
// RULE12 - Read-only parity error bit, sticky
// RULE13 - Control bit7 picks undervoltage sample interval
// RULE14 - Host writes zero to unused bits
// RULE15 - Host shutdown enable acts at zero pack
// RULE16 - State bit1 selects host or stand-alone
// RULE17 - State bit6 picks cell amplifier scale
// RULE18 - State bit7 picks current amplifier gain
// RULE19 - Function bits enable amplifiers and offset
// RULE20 - Battery or pack routed, battery wins
// RULE21 - Host mode: function bit5 powers thermistor
// RULE22 - Balance bits enable each cell bypass
`timescale 1ns/1ps
module prot_host_regs #(
	parameter int UV_SLOW_CYC = prot_regs_pkg::UV_SLOW_CYCLES,
	parameter int UV_FAST_CYC = prot_regs_pkg::UV_FAST_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_r,
	input wire logic short_circuit_in,
	input wire logic overload_in,
	input wire logic cell_high_in,
	input wire logic cell_low_in,
	input wire logic thermal_in,
	input wire logic nvm_supply_ok_in,
	input wire logic discharge_sense_in,
	input wire logic charge_sense_in,
	input wire logic nvm_parity_in,
	input wire logic pack_zero_in,
	output logic discharge_switch_r,
	output logic charge_switch_r,
	output logic open_drain_output_o_r,
	output logic open_drain_output_oe_r,
	output logic power_down_request_r,
	output logic host_mode_r,
	output logic uv_sample_tick_r,
	output logic cell_amp_scale_select_r,
	output logic current_amp_gain_select_r,
	output logic cell_amp_on_r,
	output logic current_amp_on_r,
	output logic current_amp_offset_out_r,
	output logic stack_divided_out_r,
	output logic pack_divided_out_r,
	output logic thermistor_supply_on_r,
	output logic [9:0] bypass_enable_r
);
	import prot_regs_pkg::*;

	// Address match, shared by write decode and read-side effects
	function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offset);
		reg_hit = (addr == offset);
	endfunction

	logic [9:0] sync1_r; // First synchroniser stage, read only by stage two
	logic [9:0] sync2_r; // Synchronised analog comparator levels
	logic [9:0] pins_raw; // Raw pin bundle
	logic [7:0] outctl_r; // Output control storage
	logic [7:0] state_r; // State control storage
	logic [7:0] func_r; // Function control storage
	logic [7:0] bypass_lo_r; // Lower cells bypass enables
	logic parity_seen_r; // Sticky parity error
	release_state_t rel_state_r; // Release toggle tracker
	release_state_t rel_state_nxt;
	logic [22:0] uv_cnt_r; // Sampling interval counter
	logic [22:0] uv_limit; // Terminal count for current interval
	logic [7:0] rd_mux; // Read data selection
	logic status_rd; // Status register read this cycle
	logic host; // Host-control mode active
	logic fault_dsg; // Stand-alone discharge trip
	logic fault_chg; // Stand-alone charge trip

	fault_if fault_bus ();

	fault_latch_bank u_latch (
		.clk(clk),
		.sys_rst(sys_rst),
		.fb(fault_bus.bank)
	);

	assign pins_raw = {pack_zero_in, nvm_parity_in, charge_sense_in, discharge_sense_in,
		nvm_supply_ok_in, thermal_in, cell_low_in, cell_high_in, overload_in,
		short_circuit_in};

	// Two-flop synchroniser; the comparators are asynchronous to clk
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1_r <= 10'h000;
			sync2_r <= 10'h000;
		end
		else
		begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	assign host = state_r[SC_HOST];
	assign status_rd = reg_rd && reg_hit(reg_addr, ADDR_STATUS);

	// Fault conditions into the latch bank
	assign fault_bus.cond = sync2_r[NUM_FAULTS-1:0]; // see RULE2 see RULE3 see RULE4
	assign fault_bus.status_rd = status_rd; // see RULE9
	assign fault_bus.release_p = (rel_state_r == REL_ARMED);

	// Control register writes; unused bits are not stored and read zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			outctl_r <= RST_OUTCTL;
			state_r <= RST_STATE;
			func_r <= RST_FUNC;
			bypass_lo_r <= RST_BYPASS;
		end
		else if (reg_wr)
		begin
			// Mode gating of host writes is the host's duty, not enforced here
			if (reg_hit(reg_addr, ADDR_OUTCTL))
				outctl_r <= reg_wdata & OUTCTL_WMASK; // see RULE14
			if (reg_hit(reg_addr, ADDR_STATE))
				state_r <= reg_wdata & STATE_WMASK; // see RULE16
			if (reg_hit(reg_addr, ADDR_FUNC))
				func_r <= reg_wdata;
			if (reg_hit(reg_addr, ADDR_BYPASS_LO))
				bypass_lo_r <= reg_wdata; // see RULE22
		end
	end

	// Parity error stays set until reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			parity_seen_r <= 1'b0;
		else if (sync2_r[8])
			parity_seen_r <= 1'b1; // see RULE12
	end

	// Release tracker: only a full 0-1-0 on the release bit counts
	always_comb
	begin
		rel_state_nxt = rel_state_r;
		case (rel_state_r)
			REL_IDLE:
			begin
				if (reg_wr && reg_hit(reg_addr, ADDR_OUTCTL) && reg_wdata[OC_RELEASE])
					rel_state_nxt = REL_HIGH;
			end
			REL_HIGH:
			begin
				// Falling write completes the toggle
				if (reg_wr && reg_hit(reg_addr, ADDR_OUTCTL) && !reg_wdata[OC_RELEASE])
					rel_state_nxt = REL_ARMED; // see RULE9
			end
			REL_ARMED:
			begin
				rel_state_nxt = REL_IDLE;
			end
			default:
			begin
				rel_state_nxt = REL_IDLE;
			end
		endcase
	end

	// Tracker state register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rel_state_r <= REL_IDLE;
		else
			rel_state_r <= rel_state_nxt;
	end

	// Read mux; live bits come straight from the synchronised pins
	always_comb
	begin
		rd_mux = 8'h00;
		case (reg_addr)
			ADDR_STATUS:
			begin
				rd_mux = {sync2_r[7:5], fault_bus.flags}; // see RULE7 see RULE8
			end
			ADDR_OUTCTL:
			begin
				rd_mux = outctl_r;
				rd_mux[OC_PARITY] = parity_seen_r; // see RULE12
			end
			ADDR_STATE:
			begin
				rd_mux = state_r;
			end
			ADDR_FUNC:
			begin
				rd_mux = func_r;
			end
			ADDR_BYPASS_LO:
			begin
				rd_mux = bypass_lo_r;
			end
			default:
			begin
				rd_mux = 8'h00; // Unmapped here reads zero
			end
		endcase
	end

	// Read data register, loaded on the read strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata_r <= 8'h00;
		else if (reg_rd)
			reg_rdata_r <= rd_mux;
	end

	// Stand-alone trips; parity error forces both switches off
	assign fault_dsg = |fault_bus.flags[ST_THERMAL:ST_CELL_LOW] | fault_bus.flags[ST_SHORT] |
		fault_bus.flags[ST_OVERLOAD] | parity_seen_r;
	assign fault_chg = fault_bus.flags[ST_CELL_HIGH] | fault_bus.flags[ST_THERMAL] |
		parity_seen_r;

	// Switch drive; shutdown enable turns discharge off at once, without waiting for pack zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			discharge_switch_r <= 1'b0;
			charge_switch_r <= 1'b0;
		end
		else if (host)
		begin
			discharge_switch_r <= outctl_r[OC_DISCHARGE] & ~state_r[SC_POWER_DOWN]; // see RULE10
			charge_switch_r <= outctl_r[OC_CHARGE]; // see RULE10
		end
		else
		begin
			discharge_switch_r <= ~fault_dsg;
			charge_switch_r <= ~fault_chg;
		end
	end

	// Open-drain pin: drives low only; stand-alone parity error releases it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			open_drain_output_o_r <= 1'b0;
			open_drain_output_oe_r <= 1'b0;
		end
		else
		begin
			open_drain_output_o_r <= 1'b0;
			open_drain_output_oe_r <= outctl_r[OC_OPEN_DRAIN] & (host | ~parity_seen_r); // see RULE11
		end
	end

	// Mode and shutdown; shutdown waits for the pack to reach zero volts
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			host_mode_r <= 1'b0;
			power_down_request_r <= 1'b0;
		end
		else
		begin
			host_mode_r <= host; // see RULE16
			power_down_request_r <= host & state_r[SC_POWER_DOWN] & sync2_r[9]; // see RULE15
		end
	end

	// Amplifier selects and enables
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cell_amp_scale_select_r <= 1'b0;
			current_amp_gain_select_r <= 1'b0;
			cell_amp_on_r <= 1'b0;
			current_amp_on_r <= 1'b0;
			current_amp_offset_out_r <= 1'b0;
		end
		else
		begin
			cell_amp_scale_select_r <= state_r[SC_CELL_SCALE]; // see RULE17
			current_amp_gain_select_r <= state_r[SC_CUR_GAIN]; // see RULE18
			cell_amp_on_r <= func_r[FC_CELL_AMP]; // see RULE19
			current_amp_on_r <= func_r[FC_CUR_AMP]; // see RULE19
			current_amp_offset_out_r <= func_r[FC_CUR_OFFSET]; // see RULE19
		end
	end

	// Divided stack routing; battery select overrides pack select
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stack_divided_out_r <= 1'b0;
			pack_divided_out_r <= 1'b0;
		end
		else
		begin
			stack_divided_out_r <= func_r[FC_CELL_AMP] & func_r[FC_STACK_SEL]; // see RULE20
			pack_divided_out_r <= func_r[FC_CELL_AMP] & func_r[FC_PACK_SEL] &
				~func_r[FC_STACK_SEL]; // see RULE20
		end
	end

	// Thermistor supply and bypass enables
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			thermistor_supply_on_r <= 1'b0;
			bypass_enable_r <= 10'h000;
		end
		else
		begin
			thermistor_supply_on_r <= host & func_r[FC_THERMISTOR]; // see RULE21
			bypass_enable_r <= {func_r[FC_BYPASS_10], func_r[FC_BYPASS_9], bypass_lo_r}; // see RULE22
		end
	end

	// Per-cell undervoltage sample tick; switching rate keeps the count, which ticks at once if already past the new limit
	assign uv_limit = outctl_r[OC_FAST] ? 23'(UV_FAST_CYC - 1) : 23'(UV_SLOW_CYC - 1); // see RULE13
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			uv_cnt_r <= 23'h000000;
			uv_sample_tick_r <= 1'b0;
		end
		else if (uv_cnt_r >= uv_limit)
		begin
			uv_cnt_r <= 23'h000000;
			uv_sample_tick_r <= 1'b1;
		end
		else
		begin
			uv_cnt_r <= uv_cnt_r + 23'h000001;
			uv_sample_tick_r <= 1'b0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_status_live: assert property (status_rd |=> reg_rdata_r[7:5] == $past(sync2_r[7:5])) // see RULE8
		else $error("live status bits wrong");
	chk_host_switch: assert property (host && !state_r[SC_POWER_DOWN] |=>
		discharge_switch_r == $past(outctl_r[OC_DISCHARGE])) // see RULE10
		else $error("host discharge switch mismatch");
	chk_open_drain: assert property (open_drain_output_oe_r |->
		$past(outctl_r[OC_OPEN_DRAIN]) && !open_drain_output_o_r) // see RULE11
		else $error("open drain driven without request");
	chk_parity_sticky: assert property (parity_seen_r |=> parity_seen_r) // see RULE12
		else $error("parity flag dropped");
	chk_route_priority: assert property (func_r[FC_CELL_AMP] && func_r[FC_STACK_SEL] |=>
		stack_divided_out_r && !pack_divided_out_r) // see RULE20
		else $error("battery select lost priority");
endmodule

//--- hw/prot_regs_pkg.sv
// Purpose: Shared constants for the battery protector host register bank
// Assumes: Byte-wide registers at small indexed addresses, 125 MHz clock
// Notes: Offsets, field positions, reset values and timing counts live here
package prot_regs_pkg;
	// Register addresses
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_OUTCTL = 4'h1;
	localparam logic [3:0] ADDR_STATE = 4'h2;
	localparam logic [3:0] ADDR_FUNC = 4'h3;
	localparam logic [3:0] ADDR_BYPASS_LO = 4'h4;
	// Status fields
	localparam int ST_SHORT = 0;
	localparam int ST_OVERLOAD = 1;
	localparam int ST_CELL_HIGH = 2;
	localparam int ST_CELL_LOW = 3;
	localparam int ST_THERMAL = 4;
	localparam int ST_SUPPLY_OK = 5;
	localparam int ST_DISCHARGE = 6;
	localparam int ST_CHARGE = 7;
	localparam int NUM_FAULTS = 5;
	// Output control fields
	localparam int OC_RELEASE = 0;
	localparam int OC_DISCHARGE = 1;
	localparam int OC_CHARGE = 2;
	localparam int OC_OPEN_DRAIN = 3;
	localparam int OC_PARITY = 6;
	localparam int OC_FAST = 7;
	// State control fields
	localparam int SC_POWER_DOWN = 0;
	localparam int SC_HOST = 1;
	localparam int SC_CELL_SCALE = 6;
	localparam int SC_CUR_GAIN = 7;
	// Function control fields
	localparam int FC_CELL_AMP = 0;
	localparam int FC_CUR_AMP = 1;
	localparam int FC_CUR_OFFSET = 2;
	localparam int FC_PACK_SEL = 3;
	localparam int FC_STACK_SEL = 4;
	localparam int FC_THERMISTOR = 5;
	localparam int FC_BYPASS_9 = 6;
	localparam int FC_BYPASS_10 = 7;
	// Reset values and writable masks
	localparam logic [7:0] RST_OUTCTL = 8'h00;
	localparam logic [7:0] RST_STATE = 8'h00;
	localparam logic [7:0] RST_FUNC = 8'h00;
	localparam logic [7:0] RST_BYPASS = 8'h00;
	localparam logic [7:0] OUTCTL_WMASK = 8'h8f;
	localparam logic [7:0] STATE_WMASK = 8'hc3;
	// Undervoltage sampling interval per cell
	localparam int CLK_MHZ = 125;
	localparam int UV_SLOW_MS = 50;
	localparam int UV_FAST_US = 100;
	localparam int UV_SLOW_CYCLES = UV_SLOW_MS * 1000 * CLK_MHZ;
	localparam int UV_FAST_CYCLES = UV_FAST_US * CLK_MHZ;
	// Latch release sequence tracker
	typedef enum logic [2:0] {
		REL_IDLE = 3'b001,
		REL_HIGH = 3'b010,
		REL_ARMED = 3'b100
	} release_state_t;
endpackage

//--- hw/fault_if.sv
// Purpose: Carries fault conditions, release and read events to the latch bank
// Assumes: Both ends run on the same clock
// Notes: Conditions arrive already synchronised
`timescale 1ns/1ps
interface fault_if;
	logic [4:0] cond; // Live fault conditions
	logic release_p; // One-cycle latch release event
	logic status_rd; // One-cycle status read event
	logic [4:0] flags; // Latched fault flags
	modport owner (output cond, output release_p, output status_rd, input flags);
	modport bank (input cond, input release_p, input status_rd, output flags);
endinterface

//--- hw/fault_latch_bank.sv
// Purpose: Sticky fault flags released by the host and cleared on status read
// Assumes: Release and read events are single-cycle pulses
// Notes: A live condition always beats the clear
`timescale 1ns/1ps
module fault_latch_bank (
	input wire logic clk,
	input wire logic sys_rst,
	fault_if.bank fb
);
	import prot_regs_pkg::*;

	logic clear_armed_r; // Release seen, next status read may clear
	logic [NUM_FAULTS-1:0] flag_r; // Latched fault flags

	// Arm on release, disarm once the status read consumed it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			clear_armed_r <= 1'b0;
		else if (fb.release_p)
			clear_armed_r <= 1'b1; // see RULE9
		else if (fb.status_rd)
			clear_armed_r <= 1'b0;
	end

	// One latch per fault; set wins over clear so no event is lost
	for (genvar i = 0; i < NUM_FAULTS; i++)
	begin : g_latch
		always_ff @(posedge clk)
		begin
			if (sys_rst)
				flag_r[i] <= 1'b0;
			else if (fb.cond[i])
				flag_r[i] <= 1'b1; // see RULE5 see RULE6
			else if (clear_armed_r && fb.status_rd)
				flag_r[i] <= 1'b0; // see RULE9
		end
	end

	assign fb.flags = flag_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Armed status read: only conditions still live stay flagged afterwards
	sequence s_armed_read;
		clear_armed_r && fb.status_rd;
	endsequence
	sequence s_cleared;
		fb.flags == $past(fb.cond);
	endsequence

	chk_short_latch: assert property (fb.cond[0] |=> fb.flags[0]) // see RULE2
		else $error("short flag not set");
	chk_overload_latch: assert property (fb.cond[1] |=> fb.flags[1]) // see RULE3
		else $error("overload flag not set");
	chk_high_latch: assert property (fb.cond[2] |=> fb.flags[2]) // see RULE4
		else $error("cell high flag not set");
	chk_low_latch: assert property (fb.cond[3] |=> fb.flags[3]) // see RULE5
		else $error("cell low flag not set");
	chk_thermal_latch: assert property (fb.cond[4] |=> fb.flags[4]) // see RULE6
		else $error("thermal flag not set");
	chk_release_clear: assert property (s_armed_read |=> s_cleared) // see RULE9
		else $error("latches not cleared after release");
endmodule

//--- verif/host_model.sv
// Purpose: Host controller model issuing register writes and reads
// Assumes: One-cycle strobes, taken on the rising clock edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module host_model
	import prot_regs_pkg::*;
(
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_r
);
	logic host_seen = 1'b0; // Host mode already requested by this model

	// Idle bus at time zero
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'hf;
		reg_wdata = 8'h00;
	end

	// One write; control writes are dropped until host mode is requested
	task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == ADDR_OUTCTL)
			v = d & OUTCTL_WMASK;
		if (a == ADDR_STATE)
		begin
			v = d & STATE_WMASK;
			host_seen = v[SC_HOST];
		end
		if (a == ADDR_STATE || host_seen)
		begin
			@(posedge clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= v;
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_addr <= ~a;
			reg_wdata <= ~v;
		end
	endtask

	// One read; data is held by the device until the next read
	task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		#1;
		d = reg_rdata_r;
	endtask
endmodule

//--- verif/battery_protector_host_registers_tb.sv
// Purpose: Self-checking bench for the host register bank
// Assumes: Host model drives the strobe port; bench drives the analog levels
// Notes: Sample interval counts shortened to 20 and 5 cycles
`timescale 1ns/1ps
`define CHECK(g, e) compare(16'(g), 16'(e))
module battery_protector_host_registers_tb
	import prot_regs_pkg::*;
;
	logic clk = 1'b0; // 125 MHz clock
	logic sys_rst = 1'b1; // Synchronous reset
	logic [9:0] pins = 10'h000; // Faults, supply, senses, parity, pack zero
	wire reg_wr;
	wire reg_rd;
	wire [3:0] reg_addr;
	wire [7:0] reg_wdata;
	wire [7:0] reg_rdata_r;
	wire [14:0] outs; // Control outputs, packed for compact checks
	wire [9:0] byp; // Bypass enables
	int num_errors = 0;
	int checks_done = 0;
	int i;
	logic [7:0] fv [4] = '{8'h1f, 8'h09, 8'h18, 8'h26}; // Function writes
	logic [5:0] fe [4] = '{6'b001111, 6'b010001, 6'b000000, 6'b100110};

	// Free-running clock
	always #4 clk = ~clk;

	host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));

	prot_host_regs #(.UV_SLOW_CYC(20), .UV_FAST_CYC(5)) uut (.clk(clk), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_r(reg_rdata_r), .short_circuit_in(pins[0]), .overload_in(pins[1]),
		.cell_high_in(pins[2]), .cell_low_in(pins[3]), .thermal_in(pins[4]),
		.nvm_supply_ok_in(pins[5]), .discharge_sense_in(pins[6]),
		.charge_sense_in(pins[7]), .nvm_parity_in(pins[8]), .pack_zero_in(pins[9]),
		.discharge_switch_r(outs[0]), .charge_switch_r(outs[1]),
		.open_drain_output_o_r(outs[2]), .open_drain_output_oe_r(outs[3]),
		.power_down_request_r(outs[4]), .host_mode_r(outs[5]), .uv_sample_tick_r(outs[6]),
		.cell_amp_scale_select_r(outs[7]), .current_amp_gain_select_r(outs[8]),
		.cell_amp_on_r(outs[9]), .current_amp_on_r(outs[10]),
		.current_amp_offset_out_r(outs[11]), .stack_divided_out_r(outs[12]),
		.pack_divided_out_r(outs[13]), .thermistor_supply_on_r(outs[14]),
		.bypass_enable_r(byp));

	// Compare with case equality so unknowns never match
	task automatic compare(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
			num_errors++;
		end
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Write then let the outputs follow
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host.write_reg(a, d);
		repeat (2) @(posedge clk);
		#1;
	endtask

	// Read and compare
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.read_reg(a, d);
		`CHECK(d, e);
	endtask

	// New pin levels; wait out the two-stage sync and the latch
	task automatic set_pins(input logic [9:0] v);
		@(posedge clk);
		pins <= v;
		repeat (5) @(posedge clk);
		#1;
	endtask

	// Wait for a sample tick, bounded so a dead counter cannot hang the run
	task automatic wait_tick();
		int k;
		k = 0;
		do
		begin
			@(posedge clk);
			#1;
			k++;
		end
		while (outs[6] !== 1'b1 && k < 100);
		if (k >= 100)
		begin
			num_errors++;
			end_of_test();
		end
	endtask

	// Period between two ticks in clock cycles
	task automatic measure(input int e);
		int n;
		wait_tick();
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (outs[6] !== 1'b1 && n < 100);
		`CHECK(n, e);
	endtask

	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		// Stand-alone with no latched fault: both switches already on
		`CHECK(outs, 15'h0003);
		`CHECK(byp, 10'h000);
		for (i = 0; i < 6; i++)
			rd_chk(i[3:0], 8'h00);
		set_pins(10'h0e0);
		rd_chk(ADDR_STATUS, 8'he0);
		// Host mode first, so later control writes are allowed
		wr(ADDR_STATE, 8'h02);
		`CHECK(outs[5], 1'b1);
		// Each fault flag sets and sticks after its condition goes away
		for (i = 0; i < 5; i++)
		begin
			set_pins(10'h0e0 | (10'h001 << i));
			set_pins(10'h0e0);
			rd_chk(ADDR_STATUS, 8'he0 | ((8'h02 << i) - 8'h01));
		end
		// Release with short still present: that flag must survive
		set_pins(10'h0e1);
		wr(ADDR_OUTCTL, 8'h01);
		wr(ADDR_OUTCTL, 8'h00);
		rd_chk(ADDR_STATUS, 8'hff);
		rd_chk(ADDR_STATUS, 8'he1);
		set_pins(10'h000);
		rd_chk(ADDR_STATUS, 8'h01);
		// Direct switch and open-drain control
		wr(ADDR_OUTCTL, 8'h06);
		`CHECK(outs[1:0], 2'b11);
		wr(ADDR_OUTCTL, 8'h08);
		`CHECK(outs[3:0], 4'b1000);
		rd_chk(ADDR_OUTCTL, 8'h08);
		// Shutdown with the pack at zero volts
		set_pins(10'h200);
		wr(ADDR_OUTCTL, 8'h02);
		wr(ADDR_STATE, 8'h03);
		`CHECK({outs[4], outs[0]}, 2'b10);
		wr(ADDR_STATE, 8'h02);
		`CHECK({outs[4], outs[0]}, 2'b01);
		wr(ADDR_STATE, 8'hc2);
		`CHECK(outs[8:7], 2'b11);
		rd_chk(ADDR_STATE, 8'hc2);
		// Amplifier enables, routing priority and thermistor supply
		for (i = 0; i < 4; i++)
		begin
			wr(ADDR_FUNC, fv[i]);
			`CHECK(outs[14:9], fe[i]);
			rd_chk(ADDR_FUNC, fv[i]);
		end
		wr(ADDR_FUNC, 8'hc0);
		wr(ADDR_BYPASS_LO, 8'ha5);
		`CHECK(byp, 10'h3a5);
		rd_chk(ADDR_BYPASS_LO, 8'ha5);
		// Parity error is read-only and sticky
		set_pins(10'h100);
		rd_chk(ADDR_OUTCTL, 8'h42);
		wr(ADDR_OUTCTL, 8'h02);
		set_pins(10'h000);
		rd_chk(ADDR_OUTCTL, 8'h42);
		// Sample interval, slow then fast
		measure(20);
		wr(ADDR_OUTCTL, 8'h82);
		wait_tick();
		measure(5);
		// Back to stand-alone; the latched parity error keeps both switches off
		wr(ADDR_STATE, 8'h00);
		`CHECK({outs[5], outs[1:0]}, 3'b000);
		end_of_test();
	end
endmodule
